// ### sdt_clk_div.sv
// Divider that makes the modulator clock and its edge pulses from a source tick.
`timescale 1ns/1ps
module sdt_clk_div #(
    parameter int DIV_W = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic src_pll_i,
    input wire logic pll_tick_i,
    input wire logic [DIV_W-1:0] div_i,
    output logic clk_o,
    output logic rise_o,
    output logic fall_o
);
    logic [DIV_W-1:0] cnt_q;
    wire tick = en_i & (src_pll_i ? pll_tick_i : 1'b1);
    // A divider field of zero would stop the clock, so the ratio never drops below two.
    wire [DIV_W-1:0] last = (div_i == '0) ? DIV_W'(1) : div_i;
    wire [DIV_W-1:0] cnt_d = (cnt_q >= last) ? '0 : cnt_q + DIV_W'(1);
    wire lvl_d = cnt_d <= (last >> 1);

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !en_i) begin
            cnt_q <= '0;
            clk_o <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            rise_o <= tick & lvl_d & ~clk_o;
            fall_o <= tick & ~lvl_d & clk_o;
            if (tick) begin
                cnt_q <= cnt_d;
                clk_o <= lvl_d;
            end
        end
    end
endmodule

// ### sdt_mod_model.sv
// Behavioural modulator: echoes its clock and puts two streams on one data line.
`timescale 1ns/1ps
module sdt_mod_model (
    input wire logic core_clk_i,
    input wire logic mod_clk_i,
    input wire logic rise_bit_i,
    input wire logic fall_bit_i,
    output logic clk_o,
    output logic data_o
);
    logic [2:0] seen_q = 3'h0;
    initial clk_o = 1'b0;
    initial data_o = 1'b0;
    // Data moves three cycles after an edge; this needs a period of at least 4 cycles.
    // The link clock therefore has to run at a quarter of the core clock or slower for serial data.
    always @(posedge core_clk_i) begin
        seen_q <= {seen_q[1:0], mod_clk_i};
        clk_o <= mod_clk_i;
        if (seen_q[1] && !seen_q[2]) data_o <= fall_bit_i;
        if (!seen_q[1] && seen_q[2]) data_o <= rise_bit_i;
    end
endmodule

// ### sdt_pkg.sv
// Package holding the register map, field layout and carrier types of the transceiver front end.
package sdt_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] CH_BASE_OFS = 8'h10;
    localparam logic [7:0] CH_STRIDE = 8'h08;
    localparam logic [7:0] CH_DATA_OFS = 8'h04;

    // Control register fields.
    localparam int CTRL_DIV_LSB = 0;
    localparam int CTRL_SRC_BIT = 8;
    localparam int CTRL_EN_BIT = 9;
    localparam logic [7:0] CTRL_DIV_RST = 8'h01;

    // Status register fields.
    localparam int STAT_PEND_LSB = 0;
    localparam int STAT_CLK_BIT = 8;

    // Field codes.
    localparam logic [1:0] MUX_SERIAL = 2'h0;
    localparam logic [1:0] MUX_ADC = 2'h1;
    localparam logic [1:0] MUX_BUS = 2'h2;
    localparam logic [1:0] PACK_STD = 2'h0;
    localparam logic [1:0] PACK_ILV = 2'h2;
    localparam logic [1:0] PACK_DUAL = 2'h3;
    localparam logic [1:0] CKSEL_PIN = 2'h0;
    localparam logic [1:0] CKSEL_INT = 2'h1;

    // Channel configuration, bits [7:0] of each channel_config_reg.
    typedef struct packed {
        logic redirect;
        logic edge_fall;
        logic [1:0] serial_clock_select;
        logic [1:0] sample_packing_mode;
        logic [1:0] input_source_mux;
    } sdt_ch_cfg_t;

    localparam sdt_ch_cfg_t CH_CFG_RST = 8'h00;

    // One input sample handed to the filter.
    typedef struct packed {
        logic valid;
        logic serial;
        logic [15:0] data;
    } sdt_sample_t;

endpackage

// ### sdt_transceivers.sv
// Serial and parallel input transceivers feeding the sigma-delta filter channels.
`timescale 1ns/1ps

// Function
// - Each serial channel samples its data pin on its clock and emits one sample.
// - Modulator clock equals the source clock divided by divider field plus one, or by two when the field is zero.
// - Clock select 1 samples with the internal copy of the generated clock.
// - Channel inputs can be redirected so one data pin feeds two channels.
// - Two streams share a line, one on rising and one on falling edges.
// - Clock source 0 derives the modulator clock from the block's own clock.
// - Each channel owns one 32-bit parallel register of two 16-bit halves.
// - Mux 0 feeds serial bits; mux 1 and 2 feed parallel 16-bit signed samples; mux 3 feeds nothing.
// - Mux 1 loads from the internal converter bus; mux 2 from bus writes.
// - Standard uses lower half, interleaved both in turn, dual splits channels.
// - Each lower half written gives one strobe; an upper half only when interleaved, or dual with the next channel on mux 2.
// - Interleaved packing delivers two consecutive samples to one channel.
// - Dual packing delivers one sample here and one to the next channel.
// - The divider ratio spans 2 to 256.
module sdt_transceivers #(
    parameter int NCH = 2,
    parameter int DIV_W = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Classic Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Modulator link.
    input wire logic [NCH-1:0] serial_data_pin_i,
    input wire logic [NCH-1:0] serial_clock_in_pin_i,
    output logic modulator_clock_out_pin_o,
    // Audio PLL rate, one-cycle enable pulses.
    input wire logic pll_tick_i,
    // Internal converter bus.
    input wire logic adc_valid_i,
    input wire logic [NCH-1:0][15:0] adc_data_i,
    // Samples to the filters.
    output sdt_pkg::sdt_sample_t [NCH-1:0] sample_o
);

    logic [31:0] ctrl_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [NCH-1:0] clkin_prev_q;
    logic [NCH-1:0] pend_q;
    logic clk_pin_q;
    sdt_pkg::sdt_ch_cfg_t cfg_q [NCH];
    logic [15:0] par_lo_q [NCH];
    logic [15:0] par_hi_q [NCH];
    sdt_pkg::sdt_sample_t smp_q [NCH];

    wire gen_clk;
    wire gen_rise;
    wire gen_fall;

    // Bus decode. A request is answered one cycle after it appears, and
    // writes land on the edge where the master sees the acknowledge.
    wire req = wb_cyc_i & wb_stb_i;
    wire acc_wr = req & wb_we_i & ack_q;
    wire ctrl_hit = wb_adr_i == sdt_pkg::CTRL_OFS;
    wire stat_hit = wb_adr_i == sdt_pkg::STAT_OFS;
    wire ctrl_we = acc_wr & ctrl_hit;

    wire [DIV_W-1:0] div_val = ctrl_q[sdt_pkg::CTRL_DIV_LSB +: DIV_W];
    wire clk_src_pll = ctrl_q[sdt_pkg::CTRL_SRC_BIT];
    wire clk_en = ctrl_q[sdt_pkg::CTRL_EN_BIT];

    wire [31:0] ctrl_wmask = {{22{1'b0}}, 10'h3FF};
    wire [31:0] bytemask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] ctrl_d = (ctrl_q & ~bytemask) | (wb_dat_i & bytemask & ctrl_wmask);

    wire [31:0] stat_val;
    assign stat_val = {{23{1'b0}}, clk_pin_q, 8'(pend_q)};

    // Per-channel read data and write strobes.
    logic [31:0] rd_or [NCH+1];
    logic [NCH-1:0] hi_we_v;
    logic [NCH-1:0] dual_v;
    assign rd_or[0] = ctrl_hit ? ctrl_q : (stat_hit ? stat_val : 32'h0000_0000);

    sdt_clk_div #(
        .DIV_W(DIV_W)
    ) u_div (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .en_i(clk_en),
        .src_pll_i(clk_src_pll),
        .pll_tick_i(pll_tick_i),
        .div_i(div_val),
        .clk_o(gen_clk),
        .rise_o(gen_rise),
        .fall_o(gen_fall)
    );

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            ctrl_q <= {{22{1'b0}}, 2'h0, sdt_pkg::CTRL_DIV_RST};
            clk_pin_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q) begin
                rdat_q <= rd_or[NCH];
            end
            if (ctrl_we) begin
                ctrl_q <= ctrl_d;
            end
            clk_pin_q <= gen_clk;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign modulator_clock_out_pin_o = clk_pin_q;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        localparam int NXT = (c + 1) % NCH;
        localparam int PRV = (c + NCH - 1) % NCH;
        localparam logic [7:0] CFG_ADR = 8'(sdt_pkg::CH_BASE_OFS + c * sdt_pkg::CH_STRIDE);
        localparam logic [7:0] DAT_ADR = 8'(CFG_ADR + sdt_pkg::CH_DATA_OFS);

        wire cfg_hit = wb_adr_i == CFG_ADR;
        wire dat_hit = wb_adr_i == DAT_ADR;
        sdt_pkg::sdt_ch_cfg_t cfg;
        assign cfg = cfg_q[c];

        wire [31:0] par_word = {par_hi_q[c], par_lo_q[c]};
        wire [31:0] cfg_word = {24'h00_0000, cfg_q[c]};
        assign rd_or[c+1] = rd_or[c] | (cfg_hit ? cfg_word : 32'h0000_0000)
                            | (dat_hit ? par_word : 32'h0000_0000);

        // Serial side. The redirect picks the next channel's pins, so with
        // two channels channel 0 can listen on channel 1's data line.
        wire pin_dat = cfg.redirect ? serial_data_pin_i[NXT] : serial_data_pin_i[c];
        wire pin_clk = cfg.redirect ? serial_clock_in_pin_i[NXT] : serial_clock_in_pin_i[c];
        wire pin_rise = pin_clk & ~clkin_prev_q[c];
        wire pin_fall = ~pin_clk & clkin_prev_q[c];
        wire use_int = cfg.serial_clock_select == sdt_pkg::CKSEL_INT;
        wire ck_rise = use_int ? gen_rise : pin_rise;
        wire ck_fall = use_int ? gen_fall : pin_fall;
        // Only one edge is ever active per channel, which is what lets two
        // channels split a shared line into its rising and falling streams.
        wire ser_edge = cfg.edge_fall ? ck_fall : ck_rise;
        wire is_ser = cfg.input_source_mux == sdt_pkg::MUX_SERIAL;
        wire ser_stb = is_ser & ser_edge;

        // Parallel side.
        wire is_adc = cfg.input_source_mux == sdt_pkg::MUX_ADC;
        wire is_bus = cfg.input_source_mux == sdt_pkg::MUX_BUS;
        wire dat_we = acc_wr & dat_hit & is_bus;
        wire lo_we = dat_we & (wb_sel_i[0] | wb_sel_i[1]);
        wire hi_we = dat_we & (wb_sel_i[2] | wb_sel_i[3]);
        assign hi_we_v[c] = hi_we;
        assign dual_v[c] = cfg.sample_packing_mode == sdt_pkg::PACK_DUAL;
        wire pack_ilv = cfg.sample_packing_mode == sdt_pkg::PACK_ILV;
        // Converter data only ever lands in the lower half.
        wire adc_we = adc_valid_i & is_adc;
        // The upper half of a dual write on the previous channel arrives here.
        wire dual_in = (NCH > 1) & hi_we_v[PRV] & dual_v[PRV] & is_bus;

        wire [15:0] lo_merge = {wb_sel_i[1] ? wb_dat_i[15:8] : par_lo_q[c][15:8],
                                wb_sel_i[0] ? wb_dat_i[7:0] : par_lo_q[c][7:0]};
        wire [15:0] hi_merge = {wb_sel_i[3] ? wb_dat_i[31:24] : par_hi_q[c][15:8],
                                wb_sel_i[2] ? wb_dat_i[23:16] : par_hi_q[c][7:0]};
        wire [15:0] dual_word = {wb_sel_i[3] ? wb_dat_i[31:24] : 8'h00,
                                 wb_sel_i[2] ? wb_dat_i[23:16] : 8'h00};

        logic [15:0] lo_d;
        always_comb begin
            lo_d = par_lo_q[c];
            if (adc_we) begin
                lo_d = adc_data_i[c];
            end else if (lo_we) begin
                lo_d = lo_merge;
            end else if (dual_in) begin
                lo_d = dual_word;
            end
        end

        // Each freshly written lower half is one sample in every packing mode.
        wire lo_stb = adc_we | lo_we | dual_in;
        // An interleaved upper half waits one cycle so it follows the lower one.
        wire pend_set = hi_we & pack_ilv;
        wire par_stb = lo_stb | pend_q[c];
        wire [15:0] par_out = pend_q[c] ? par_hi_q[c] : lo_d;

        sdt_pkg::sdt_sample_t smp_d;
        always_comb begin
            smp_d.valid = ser_stb | (~is_ser & par_stb);
            smp_d.serial = is_ser;
            smp_d.data = is_ser ? {15'h0000, pin_dat} : par_out;
        end

        // The previous pin level follows the pin through reset as well, so a
        // pin that idles high gives no false edge on the first cycle after it.
        always_ff @(posedge core_clk_i) begin
            clkin_prev_q[c] <= pin_clk;
            if (!rst_n_i) begin
                cfg_q[c] <= sdt_pkg::CH_CFG_RST;
                pend_q[c] <= 1'b0;
                par_lo_q[c] <= 16'h0000;
                par_hi_q[c] <= 16'h0000;
                smp_q[c] <= '0;
            end else begin
                if (acc_wr & cfg_hit & wb_sel_i[0]) begin
                    cfg_q[c] <= wb_dat_i[7:0];
                end
                pend_q[c] <= pend_set;
                par_lo_q[c] <= lo_d;
                if (hi_we) begin
                    par_hi_q[c] <= hi_merge;
                end
                smp_q[c] <= smp_d;
            end
        end

        assign sample_o[c] = smp_q[c];
    end

endmodule

// ### sdt_transceivers_props.sv
// Checker for bus answers and sample strobes of the transceivers.
`timescale 1ns/1ps
module sdt_transceivers_props #(
    parameter int NCH = 2
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic adc_valid_i,
    input wire logic [NCH-1:0][15:0] adc_data_i,
    input wire sdt_pkg::sdt_sample_t [NCH-1:0] sample_o
);
    sdt_pkg::sdt_ch_cfg_t c0_q;
    sdt_pkg::sdt_ch_cfg_t c1_q;
    logic wr_w;
    logic pw_w;
    assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign pw_w = wr_w && wb_adr_i == 8'h14 && c0_q.input_source_mux == sdt_pkg::MUX_BUS;
    // Shadow copies of the channel setups, since the checker cannot see inside.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            c0_q <= sdt_pkg::CH_CFG_RST;
            c1_q <= sdt_pkg::CH_CFG_RST;
        end else if (wr_w && wb_sel_i[0]) begin
            if (wb_adr_i == 8'h10) c0_q <= wb_dat_i[7:0];
            if (wb_adr_i == 8'h18) c1_q <= wb_dat_i[7:0];
        end
    end
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    property p_low;
        pw_w && wb_sel_i[1:0] != 2'h0 |=> sample_o[0].valid && !sample_o[0].serial
            && sample_o[0].data == $past(wb_dat_i[15:0]);
    endproperty
    a_low: assert property (p_low) else $error("lower sample");
    property p_ilv;
        pw_w && wb_sel_i == 4'hF && c0_q.sample_packing_mode == sdt_pkg::PACK_ILV
            |=> ##1 sample_o[0].valid && sample_o[0].data == $past(wb_dat_i[31:16], 2);
    endproperty
    a_ilv: assert property (p_ilv) else $error("upper sample");
    property p_std;
        pw_w && c0_q.sample_packing_mode == sdt_pkg::PACK_STD |=> ##1 !sample_o[0].valid;
    endproperty
    a_std: assert property (p_std) else $error("extra sample");
    property p_dual;
        pw_w && wb_sel_i == 4'hF && c0_q.sample_packing_mode == sdt_pkg::PACK_DUAL
            && c1_q.input_source_mux == sdt_pkg::MUX_BUS
            |=> sample_o[1].valid && sample_o[1].data == $past(wb_dat_i[31:16]);
    endproperty
    a_dual: assert property (p_dual) else $error("dual sample");
    property p_adc;
        adc_valid_i && c0_q.input_source_mux == sdt_pkg::MUX_ADC
            |=> sample_o[0].valid && sample_o[0].data == $past(adc_data_i[0]);
    endproperty
    a_adc: assert property (p_adc) else $error("adc sample");
    property p_adc_no;
        adc_valid_i && c1_q.input_source_mux == sdt_pkg::MUX_BUS |=> !sample_o[1].valid;
    endproperty
    a_adc_no: assert property (p_adc_no) else $error("adc leak");
    property p_ser;
        sample_o[0].valid && sample_o[0].serial |-> c0_q.input_source_mux == sdt_pkg::MUX_SERIAL;
    endproperty
    a_ser: assert property (p_ser) else $error("serial leak");
endmodule
bind sdt_transceivers sdt_transceivers_props #(.NCH(NCH)) i_sdt_transceivers_props (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .adc_valid_i(adc_valid_i), .adc_data_i(adc_data_i),
    .sample_o(sample_o));

// ### sdt_transceivers_tb.sv
// Self-checking bench of the transceivers.
`timescale 1ns/1ps
module sdt_transceivers_tb;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, pll_tick = 1'b0, adc_valid = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
    logic wb_ack, mod_clk, m_clk, m_data, rise_bit = 1'b0, fall_bit = 1'b1;
    logic [1:0][15:0] adc_data = {16'h7FFE, 16'h8001};
    sdt_pkg::sdt_sample_t [1:0] smp;
    logic [17:0] q[$];
    logic [7:0] tdiv[5] = '{8'h01, 8'h02, 8'h07, 8'hFF, 8'h01};
    logic tsrc[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    int tper[5] = '{2, 3, 8, 256, 4};
    int thi[5] = '{1, 2, 4, 128, 2};
    logic [1:0] tpk[3] = '{2'h0, 2'h2, 2'h3};
    logic [17:0] te1[3] = '{18'h0, 18'h0A5C3, 18'h2A5C3};
    int n_mismatch = 0, check_count = 0, cyc_n = 0, per, hi, n1;
    always #4 core_clk_i = ~core_clk_i;
    sdt_transceivers i_sdt_transceivers (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .serial_data_pin_i({m_data, ~m_data}), .serial_clock_in_pin_i({m_clk, ~m_clk}),
        .modulator_clock_out_pin_o(mod_clk), .pll_tick_i(pll_tick),
        .adc_valid_i(adc_valid), .adc_data_i(adc_data), .sample_o(smp));
    sdt_mod_model i_sdt_mod_model (.core_clk_i(core_clk_i), .mod_clk_i(mod_clk),
        .rise_bit_i(rise_bit), .fall_bit_i(fall_bit), .clk_o(m_clk), .data_o(m_data));
    always @(posedge core_clk_i) begin
        cyc_n <= cyc_n + 1;
        pll_tick <= ~pll_tick;
        // Queue entries hold the channel, the serial flag and the data.
        for (int c = 0; c < 2; c++)
            if (smp[c].valid === 1'b1) q.push_back({c[0], smp[c].serial, smp[c].data});
        if (cyc_n == 40000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_wdat} <= {2'b11, w, 4'hF, a, d};
        @(posedge core_clk_i);
        while (wb_ack !== 1'b1) @(posedge core_clk_i);
        rd = wb_rdat;
        {wb_cyc, wb_stb} <= 2'b00;
    endtask
    task take(input int n, input logic [17:0] e0, input logic [17:0] e1);
        repeat (4) @(posedge core_clk_i);
        check("sample count", 32'(q.size()), 32'(n));
        if (n > 0) check("first sample", 32'(q[0]), 32'(e0));
        if (n > 1) check("second sample", 32'(q[1]), 32'(e1));
        q.delete();
    endtask
    task meas();
        logic p;
        for (int k = 0; k < 2; k++) do begin
            p = mod_clk;
            @(posedge core_clk_i);
        end while (!(mod_clk && !p));
        per = 0;
        hi = 0;
        do begin
            hi += mod_clk;
            p = mod_clk;
            @(posedge core_clk_i);
            per++;
        end while (!(mod_clk && !p));
    endtask
    task complete_run();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        wb(1'b0, 8'h00, 32'h0);
        check("ctrl reset", rd, 32'h00000001);
        wb(1'b1, 8'hFC, 32'hFFFFFFFF);
        wb(1'b0, 8'hFC, 32'h0);
        check("unmapped read", rd, 32'h0);
        $display("Test registers done");
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, 8'h00, {22'h0, 1'b1, tsrc[i], tdiv[i]});
            meas();
            check("clock period", 32'(per), 32'(tper[i]));
            check("clock high", 32'(hi), 32'(thi[i]));
        end
        $display("Test divider done");
        for (int f = 0; f < 2; f++) begin
            wb(1'b1, 8'h00, 32'h0);
            rise_bit <= f[0];
            fall_bit <= ~f[0];
            wb(1'b1, 8'h10, 32'h000000D0);
            wb(1'b1, 8'h18, 32'({f[0], 4'h0}));
            wb(1'b1, 8'h00, 32'h00000207);
            repeat (40) @(posedge core_clk_i);
            q.delete();
            repeat (128) @(posedge core_clk_i);
            n1 = 0;
            foreach (q[k]) begin
                n1 += q[k][17];
                check("serial bit", 32'({q[k][16], q[k][0]}), 32'({1'b1, q[k][17] ^ ~f[0]}));
            end
            check("bits per channel", 32'({n1 inside {[15:17]}, q.size() - n1 inside {[15:17]}}),
                32'h3);
        end
        $display("Test serial done");
        wb(1'b1, 8'h00, 32'h0);
        repeat (20) @(posedge core_clk_i);
        q.delete();
        wb(1'b1, 8'h18, 32'h00000002);
        for (int p = 0; p < 3; p++) begin
            wb(1'b1, 8'h10, {28'h0, tpk[p], 2'h2});
            wb(1'b1, 8'h14, 32'hA5C38001);
            take(p > 0 ? 2 : 1, 18'h08001, te1[p]);
        end
        wb(1'b1, 8'h10, 32'h00000001);
        wb(1'b1, 8'h14, 32'h12345678);
        take(0, 18'h0, 18'h0);
        adc_valid <= 1'b1;
        @(posedge core_clk_i);
        adc_valid <= 1'b0;
        take(1, 18'h08001, 18'h0);
        $display("Test parallel done");
        complete_run();
    end
endmodule
